// >>> src/vcf_top.sv
`timescale 1ns/1ps
module vcf_top (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     port_input_clock,
  input  wire logic [vcf_pkg::DW-1:0]   vid_data,
  input  wire logic [1:0]               mode_sel,
  input  wire logic                     port_enable,
  input  wire logic                     width_10b,
  input  wire logic [vcf_pkg::LCW-1:0]  transfer_line_count,
  output vcf_pkg::vcf_dma_s             dma_o,
  output logic                          port_synced
);
  import vcf_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  vcf_cfg_s       cfg_r;
  vcf_cfg_s       cfg_nxt;
  logic           lrst_s1_r;
  logic           lrst_s2_r;
  vcf_cfg_s       cfg_s1_r;
  vcf_cfg_s       cfg_l_r;
  vcf_cfg_s       cfg_p_r;
  logic [DW-1:0]  in_r;
  vcf_word_s      w;
  vcf_trs_s       trs;
  vcf_state_e     st_r;
  vcf_state_e     st_nxt;
  logic           cur_f_r;
  logic           cur_f_nxt;
  logic           cur_v_r;
  logic           cur_v_nxt;
  logic           cur_h_r;
  logic           cur_h_nxt;
  logic           have_r;
  logic           have_nxt;
  logic [LCW-1:0] lines_r;
  logic [LCW-1:0] lines_nxt;
  logic [DW-1:0]  wd_r;
  logic [DW-1:0]  wd_nxt;
  logic           fld_r;
  logic           fld_nxt;
  logic           tg_r;
  logic           tg_nxt;
  logic           legal;
  logic           chg;
  logic           sync_hit;
  logic           sav;
  logic           fwd;
  logic           clk_port;
  logic           run_r;
  logic           run_nxt;

  // Short local name for the link clock; every link flop runs on it
  assign clk_port = port_input_clock;

  // ---------------------------------------------------------------------------
  // System side configuration
  // ---------------------------------------------------------------------------
  // Held in flops so the port side synchronises a clean registered value
  always_comb
  begin
    cfg_nxt = '{en: port_enable, mode: mode_sel, w10: width_10b,
                lines: transfer_line_count};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cfg_r <= '0;
    else
      cfg_r <= cfg_nxt;
  end

  // ---------------------------------------------------------------------------
  // Crossing into the port clock
  // ---------------------------------------------------------------------------
  // Configuration is quasi-static; a torn multi-bit sample only lasts one
  // port edge; a tear in en, mode or w10 shows as a change and forces a resync, a tear in lines does not
  always_ff @(posedge clk_port)
  begin
    lrst_s1_r <= rst_n;
    lrst_s2_r <= lrst_s1_r;
    cfg_s1_r  <= cfg_r;
    cfg_l_r   <= cfg_s1_r;
  end

  // Previous config and sample register at the pins
  always_ff @(posedge clk_port)
  begin
    if (!lrst_s2_r)
    begin
      cfg_p_r <= '0;
      in_r    <= WORD_RST;
    end
    else
    begin
      cfg_p_r <= cfg_l_r;
      in_r    <= vid_data;
    end
  end

  // ---------------------------------------------------------------------------
  // Reference decoder
  // ---------------------------------------------------------------------------
  vcf_trs_decode u_dec (
    .clk_port (clk_port),
    .lrst_n   (lrst_s2_r),
    .din      (in_r),
    .w10      (cfg_l_r.w10),
    .word_o   (w),
    .trs_o    (trs)
  );

  // ---------------------------------------------------------------------------
  // Field tracking, line counting and sample filter
  // ---------------------------------------------------------------------------
  // Field 1 starts at the first reference with F low and V high that
  // follows field 2 or active video; mid-field power up waits a full field
  always_comb
  begin
    legal = cfg_l_r.en && (cfg_l_r.mode != 2'b11);
    chg   = (cfg_l_r.en != cfg_p_r.en) || (cfg_l_r.mode != cfg_p_r.mode)
            || (cfg_l_r.w10 != cfg_p_r.w10);
    sync_hit = trs.ev && !trs.f && trs.v && have_r
               && (cur_f_r || !cur_v_r);
    sav       = trs.ev && !trs.h && !trs.v;
    st_nxt    = st_r;
    lines_nxt = lines_r;
    cur_f_nxt = cur_f_r;
    cur_v_nxt = cur_v_r;
    cur_h_nxt = cur_h_r;
    have_nxt  = have_r;
    if (trs.ev)
    begin
      cur_f_nxt = trs.f;
      cur_v_nxt = trs.v;
      cur_h_nxt = trs.h;
      have_nxt  = 1'b1;
    end
    unique case (st_r)
      ST_UNSYNC:
        if (legal && sync_hit)
        begin
          lines_nxt = LINES_RST;
          st_nxt    = (cfg_l_r.mode == VCF_ACT) ? ST_WAIT_SAV : ST_RUN;
        end
      ST_WAIT_SAV:
        if (sav)
        begin
          if (cfg_l_r.lines == LINES_RST)
            st_nxt = ST_UNSYNC;
          else
          begin
            st_nxt    = ST_RUN;
            lines_nxt = lines_r + 16'h0001;
          end
        end
      ST_RUN:
        if (cfg_l_r.mode == VCF_ACT)
        begin
          if (sync_hit)
          begin
            st_nxt    = ST_WAIT_SAV;
            lines_nxt = LINES_RST;
          end
          else if (sav)
          begin
            if (lines_r >= cfg_l_r.lines)
              st_nxt = ST_UNSYNC;
            else
              lines_nxt = lines_r + 16'h0001;
          end
        end
      default:
        st_nxt = ST_UNSYNC;
    endcase
    if (chg || !legal)
      st_nxt = ST_UNSYNC;
    run_nxt = (st_nxt == ST_RUN);
    // Per-mode forwarding decision for the word leaving the decoder
    unique case (cfg_l_r.mode)
      VCF_ACT:
        fwd = (st_r == ST_RUN) && !w.ctl && !cur_h_r && !cur_v_r;
      VCF_VBL:
        fwd = (st_r == ST_RUN) && !w.ctl && cur_v_r;
      VCF_ENT:
        fwd = (st_r == ST_RUN) || ((st_r == ST_UNSYNC) && sync_hit);
      default:
        fwd = 1'b0;
    endcase
    fwd     = fwd && legal && !chg;
    wd_nxt  = wd_r;
    fld_nxt = fld_r;
    tg_nxt  = tg_r;
    if (fwd)
    begin
      wd_nxt  = w.data;
      fld_nxt = trs.ev ? trs.f : cur_f_r;
      tg_nxt  = !tg_r;
    end
  end

  // Filter registers; the word and toggle are held for the system side
  always_ff @(posedge clk_port)
  begin
    if (!lrst_s2_r)
    begin
      st_r    <= ST_UNSYNC;
      cur_f_r <= 1'b0;
      cur_v_r <= 1'b0;
      cur_h_r <= 1'b0;
      have_r  <= 1'b0;
      lines_r <= LINES_RST;
      wd_r    <= WORD_RST;
      fld_r   <= 1'b0;
      tg_r    <= 1'b0;
      run_r   <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      cur_f_r <= cur_f_nxt;
      cur_v_r <= cur_v_nxt;
      cur_h_r <= cur_h_nxt;
      have_r  <= have_nxt;
      lines_r <= lines_nxt;
      wd_r    <= wd_nxt;
      fld_r   <= fld_nxt;
      tg_r    <= tg_nxt;
      run_r   <= run_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Back to the system clock
  // ---------------------------------------------------------------------------
  // One toggle per word keeps order; needs the port clock well under the
  // system clock so each held word outlasts the synchroniser. The run level
  // crosses from a flop, so no decode glitch can reach the synchroniser
  vcf_cdc_word u_cdc (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .tg       (tg_r),
    .fld      (fld_r),
    .din      (wd_r),
    .lvl      (run_r),
    .dma_o    (dma_o),
    .lvl_o    (port_synced)
  );

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  no_hblank_a: assert property (@(posedge clk_port) disable iff (!lrst_s2_r)
    (fwd && cfg_l_r.mode == VCF_ACT) |-> !cur_h_r && st_r == ST_RUN)
    else $error("active mode forwarded a horizontal blanking sample");

  no_vblank_a: assert property (@(posedge clk_port) disable iff (!lrst_s2_r)
    (fwd && cfg_l_r.mode == VCF_ACT) |=> !$past(cur_v_r) && tg_r != $past(tg_r))
    else $error("active mode forwarded a vertical blanking sample");

  ctl_strip_a: assert property (@(posedge clk_port) disable iff (!lrst_s2_r)
    (trs.ev && cfg_l_r.mode != VCF_ENT) |-> !fwd ##1 !fwd ##1 !fwd ##1 !fwd)
    else $error("timing reference word forwarded outside entire mode");

  sav_wait_a: assert property (@(posedge clk_port) disable iff (!lrst_s2_r)
    (st_r == ST_WAIT_SAV && !sav) |=> tg_r == $past(tg_r))
    else $error("sample captured before start of active video");

  line_limit_a: assert property (@(posedge clk_port) disable iff (!lrst_s2_r)
    (fwd && cfg_l_r.mode == VCF_ACT) |-> lines_r != LINES_RST
      && lines_r <= cfg_l_r.lines)
    else $error("line count exceeded");

  vblank_only_a: assert property (@(posedge clk_port) disable iff (!lrst_s2_r)
    (fwd && cfg_l_r.mode == VCF_VBL) |-> cur_v_r && !w.ctl)
    else $error("blanking mode forwarded an active line sample");

  entire_pass_a: assert property (@(posedge clk_port) disable iff (!lrst_s2_r)
    (st_r == ST_RUN && cfg_l_r.mode == VCF_ENT && legal && !chg)
      |=> tg_r != $past(tg_r) && wd_r == $past(w.data))
    else $error("entire mode dropped a sample");

  entire_start_a: assert property (@(posedge clk_port) disable iff (!lrst_s2_r)
    (st_r == ST_UNSYNC && sync_hit && legal && !chg && cfg_l_r.mode == VCF_ENT)
      |-> fwd ##1 st_r == ST_RUN)
    else $error("entire mode did not start at field 1");

  mode_resync_a: assert property (@(posedge clk_port) disable iff (!lrst_s2_r)
    chg |=> st_r == ST_UNSYNC && tg_r == $past(tg_r))
    else $error("mode change did not drop synchronisation");

  dma_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dma_o.valid |-> dma_o.data == wd_r ##1 !dma_o.valid)
    else $error("delivered word differs from held word");

  sync_seen_c: cover property (@(posedge clk_port) disable iff (!lrst_s2_r)
    st_r == ST_UNSYNC ##1 st_r != ST_UNSYNC);

  sav_start_c: cover property (@(posedge clk_port) disable iff (!lrst_s2_r)
    st_r == ST_WAIT_SAV ##1 st_r == ST_RUN);

  quota_met_c: cover property (@(posedge clk_port) disable iff (!lrst_s2_r)
    st_r == ST_RUN && sav && lines_r >= cfg_l_r.lines);

  dma_out_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    dma_o.valid);

endmodule // vcf_top

// >>> src/vcf_pkg.sv
// ---------------------------------------------------------------------------
// Overview of operation
// - Active-only: drop every sample between end and start of active video.
// - Active-only: drop all samples while the stream is in vertical blanking.
// - Active-only: timing reference words are stripped, never sent to DMA.
// - Active-only: after field 1 sync, ignore samples until the start code of an active line (V low).
// - Active-only: capture at most the programmed number of lines per frame.
// - Blanking-only: forward vertical blanking data only, drop active lines.
// - Entire-field: forward the whole stream unfiltered, control words too.
// - Entire-field: transfer starts at once on field 1 sync, no wait.
// - Every forwarded word reaches the DMA side in arrival order.
// - Exactly three sub-modes: active only, blanking only, entire field.
// - Samples are 8 or 10 bits wide; both widths are accepted.
// - Embedded line and field preambles are decoded to find boundaries.
// ---------------------------------------------------------------------------
package vcf_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int DW  = 10;
  localparam int LCW = 16;

  // ---------------------------------------------------------------------------
  // Timing reference layout
  // ---------------------------------------------------------------------------
  localparam logic [7:0] TRS_ONES = 8'hFF;
  localparam logic [7:0] TRS_ZERO = 8'h00;
  localparam int         XY_MARK  = 7;
  localparam int         XY_F     = 6;
  localparam int         XY_V     = 5;
  localparam int         XY_H     = 4;
  // Words that follow the first preamble word inside one reference
  localparam logic [1:0] CTL_TAIL = 2'h3;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [DW-1:0]  WORD_RST  = 10'h000;
  localparam logic [LCW-1:0] LINES_RST = 16'h0000;

  // ---------------------------------------------------------------------------
  // Modes and states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VCF_ACT = 2'b00,
    VCF_VBL = 2'b01,
    VCF_ENT = 2'b10
  } vcf_mode_e;

  typedef enum logic [1:0] {
    ST_UNSYNC   = 2'b00,
    ST_WAIT_SAV = 2'b01,
    ST_RUN      = 2'b10
  } vcf_state_e;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic           en;
    logic [1:0]     mode;
    logic           w10;
    logic [LCW-1:0] lines;
  } vcf_cfg_s;

  typedef struct packed {
    logic ev;
    logic f;
    logic v;
    logic h;
  } vcf_trs_s;

  typedef struct packed {
    logic          ctl;
    logic [DW-1:0] data;
  } vcf_word_s;

  typedef struct packed {
    logic          valid;
    logic          field;
    logic [DW-1:0] data;
  } vcf_dma_s;

  // Upper eight bits carry the code in 10-bit mode, low eight in 8-bit mode
  function automatic logic [7:0] vcf_key(input logic [DW-1:0] d, input logic w10);
    return w10 ? d[9:2] : d[7:0];
  endfunction

endpackage

// >>> src/vcf_trs_decode.sv
`timescale 1ns/1ps
module vcf_trs_decode (
  input  wire logic              clk_port,
  input  wire logic              lrst_n,
  input  wire logic [vcf_pkg::DW-1:0] din,
  input  wire logic              w10,
  output vcf_pkg::vcf_word_s     word_o,
  output vcf_pkg::vcf_trs_s      trs_o
);
  import vcf_pkg::*;

  logic [DW-1:0] pipe_r [4];
  logic [DW-1:0] pipe_nxt [4];
  logic [1:0]    tail_r;
  logic [1:0]    tail_nxt;
  logic [7:0]    k0;
  logic [7:0]    k1;
  logic [7:0]    k2;
  logic [7:0]    k3;
  logic          hit;

  // ---------------------------------------------------------------------------
  // Preamble search over a four word window
  // ---------------------------------------------------------------------------
  // Oldest word leaves the window just as its status word arrives, so all
  // four words of a reference can be marked as control before they go on
  always_comb
  begin
    k0  = vcf_key(pipe_r[0], w10);
    k1  = vcf_key(pipe_r[1], w10);
    k2  = vcf_key(pipe_r[2], w10);
    k3  = vcf_key(pipe_r[3], w10);
    hit = (k3 == TRS_ONES) && (k2 == TRS_ZERO) && (k1 == TRS_ZERO)
          && k0[XY_MARK];
    pipe_nxt[0] = din;
    pipe_nxt[1] = pipe_r[0];
    pipe_nxt[2] = pipe_r[1];
    pipe_nxt[3] = pipe_r[2];
    if (hit)
      tail_nxt = CTL_TAIL;
    else if (tail_r != 2'h0)
      tail_nxt = tail_r - 2'h1;
    else
      tail_nxt = tail_r;
    word_o = '{ctl: hit || (tail_r != 2'h0), data: pipe_r[3]};
    trs_o  = '{ev: hit, f: k0[XY_F], v: k0[XY_V], h: k0[XY_H]};
  end

  // Window registers
  always_ff @(posedge clk_port)
  begin
    if (!lrst_n)
    begin
      for (int i = 0; i < 4; i++)
        pipe_r[i] <= WORD_RST;
      tail_r <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        pipe_r[i] <= pipe_nxt[i];
      tail_r <= tail_nxt;
    end
  end

endmodule // vcf_trs_decode

// >>> src/vcf_cdc_word.sv
`timescale 1ns/1ps
module vcf_cdc_word (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          tg,
  input  wire logic          fld,
  input  wire logic [vcf_pkg::DW-1:0] din,
  input  wire logic          lvl,
  output vcf_pkg::vcf_dma_s  dma_o,
  output logic               lvl_o
);
  import vcf_pkg::*;

  logic     tg_s1_r;
  logic     tg_s2_r;
  logic     tg_s3_r;
  logic     lv_s1_r;
  logic     lv_s2_r;
  vcf_dma_s dma_r;
  vcf_dma_s dma_nxt;

  // ---------------------------------------------------------------------------
  // Toggle crossing with held data
  // ---------------------------------------------------------------------------
  // The link side holds word and field steady for a whole port clock after
  // each toggle, which outlasts the three system edges taken here
  always_comb
  begin
    dma_nxt       = dma_r;
    dma_nxt.valid = tg_s2_r ^ tg_s3_r;
    if (tg_s2_r ^ tg_s3_r)
    begin
      dma_nxt.field = fld;
      dma_nxt.data  = din;
    end
  end

  // Synchroniser chains and output word
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_s3_r <= 1'b0;
      lv_s1_r <= 1'b0;
      lv_s2_r <= 1'b0;
      dma_r   <= '0;
    end
    else
    begin
      tg_s1_r <= tg;
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
      lv_s1_r <= lvl;
      lv_s2_r <= lv_s1_r;
      dma_r   <= dma_nxt;
    end
  end

  assign dma_o = dma_r;
  assign lvl_o = lv_s2_r;

endmodule // vcf_cdc_word

// >>> verification/vcf_src_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Video source model: port clock and one sample per edge
// ---------------------------------------------------------------------------
module vcf_src_model (
  output logic                    clk_port,
  input  wire logic               w10,
  output logic [vcf_pkg::DW-1:0]  vid_data
);
  import vcf_pkg::*;

  // Free-running port clock, far below half the system rate, odd start phase
  initial
  begin
    clk_port = 1'b0;
    vid_data = WORD_RST;
    #37;
    forever #80 clk_port = ~clk_port;
  end

  // Code byte sits on [7:0] for 8-bit links and on [9:2] for 10-bit links
  function automatic logic [DW-1:0] place(input logic [7:0] k);
    return w10 ? {k, 2'h0} : {2'h0, k};
  endfunction

  // The link has no qualifier, so callers must keep calling without gaps
  task automatic send(input logic [DW-1:0] w);
    @(posedge clk_port);
    #2;
    vid_data = w;
  endtask

endmodule  // vcf_src_model

// >>> verification/vcf_top_tb_top.sv
`timescale 1ns/1ps
module vcf_top_tb_top;
  import vcf_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals and bench state
  // ---------------------------------------------------------------------------
  logic            clk_sys;
  logic            rst_n;
  logic            clk_port;
  logic [DW-1:0]   vid_data;
  logic [1:0]      mode_sel;
  logic            port_enable;
  logic            width_10b;
  logic [LCW-1:0]  transfer_line_count;
  vcf_dma_s        dma_o;
  logic            port_synced;
  logic [DW+1:0]   exp_q[$];
  logic [DW+1:0]   ent;
  int              miscompares;
  int              checks;
  int              seed;
  int              st;
  int              lc;
  logic            seen_trs;
  logic            pf;
  logic            pv;
  logic            fld;

  vcf_top i_vcf_top (
    .clk_sys             (clk_sys),
    .rst_n               (rst_n),
    .port_input_clock    (clk_port),
    .vid_data            (vid_data),
    .mode_sel            (mode_sel),
    .port_enable         (port_enable),
    .width_10b           (width_10b),
    .transfer_line_count (transfer_line_count),
    .dma_o               (dma_o),
    .port_synced         (port_synced)
  );

  vcf_src_model i_vcf_src_model (
    .clk_port (clk_port),
    .w10      (width_10b),
    .vid_data (vid_data)
  );

  // System clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------------------
  // Checking and reporting
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [DW:0] seen, input logic [DW:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Stimulus with expected words noted as they are sent
  // ---------------------------------------------------------------------------
  // Reserved codes 00 and FF are kept out of ordinary samples
  function automatic logic [DW-1:0] smp();
    logic [31:0] r;
    logic [7:0]  k;
    r = $random(seed);
    k = 8'h01 + 8'(r % 32'd254);
    return width_10b ? {k, r[9:8]} : {2'h0, k};
  endfunction

  function automatic logic kp(input logic v, input logic act);
    return st == 2 && (mode_sel == VCF_ENT || (mode_sel == VCF_VBL && v)
                       || (mode_sel == VCF_ACT && act && !v));
  endfunction

  // Field is only checked on non-control words
  task automatic put(input logic [DW-1:0] w, input logic keep, input logic ctl);
    if (keep)
    begin
      exp_q.push_back({!ctl, fld, w});
    end
    i_vcf_src_model.send(w);
  endtask

  task automatic tref(input logic f, input logic v, input logic h);
    logic [7:0] xy;
    logic       k;
    xy = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    k = st == 2 && mode_sel == VCF_ENT;
    put(i_vcf_src_model.place(TRS_ONES), k, 1'b1);
    put(i_vcf_src_model.place(TRS_ZERO), k, 1'b1);
    put(i_vcf_src_model.place(TRS_ZERO), k, 1'b1);
    put(i_vcf_src_model.place(xy), k, 1'b1);
  endtask

  // One line: end code, two blanking words, start code, n samples
  task automatic line(input logic f, input logic v, input int n);
    if (seen_trs && (pf || !pv) && !f && v && port_enable && mode_sel != 2'h3)
    begin
      st = (mode_sel == VCF_ACT) ? 1 : 2;
      lc = 0;
    end
    seen_trs = 1'b1;
    pf = f;
    pv = v;
    tref(f, v, 1'b1);
    fld = f;
    put(i_vcf_src_model.place(8'h10), kp(v, 1'b0), 1'b0);
    put(i_vcf_src_model.place(8'h80), kp(v, 1'b0), 1'b0);
    tref(f, v, 1'b0);
    if (mode_sel == VCF_ACT && !v && st != 0)
    begin
      if (lc == transfer_line_count)
      begin
        st = 0;
      end
      else
      begin
        st = 2;
        lc++;
      end
    end
    repeat (n) put(smp(), kp(v, 1'b1), 1'b0);
  endtask

  task automatic frame();
    repeat (2) line(1'b0, 1'b1, 2);
    repeat (2) line(1'b0, 1'b0, 4);
    line(1'b1, 1'b1, 2);
    repeat (2) line(1'b1, 1'b0, 4);
  endtask

  // Reset spans 12 port cycles so the link side sees it too
  task automatic run(input logic [1:0] m, input logic w, input logic [LCW-1:0] c,
                     input logic e);
    @(posedge clk_sys);
    #2;
    rst_n = 1'b0;
    mode_sel = m;
    width_10b = w;
    transfer_line_count = c;
    port_enable = e;
    exp_q.delete();
    st = 0;
    seen_trs = 1'b0;
    repeat (12) @(posedge clk_port);
    @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    repeat (4) @(posedge clk_port);
    #2;
    chk({10'h0, port_synced}, 11'h000);
    line(1'b1, 1'b0, 4);
    repeat (2) frame();
    // Blanking runs switch to entire mode in mid stream; the filter must drop
    // sync, so the tail of the last active line is never forwarded
    if (m == VCF_VBL)
    begin
      @(posedge clk_sys);
      #2;
      mode_sel = VCF_ENT;
    end
    line(1'b0, 1'b1, 16);
    chk({10'h0, port_synced}, {10'h0, st == 2});
    chk({10'h0, exp_q.size() <= 12}, 11'h001);
    $display("Test mode %h width %0d count %0d enable %0d done", m, w, c, e);
  endtask

  // ---------------------------------------------------------------------------
  // Output watcher: each valid word takes the oldest note
  // ---------------------------------------------------------------------------
  // Sampled on the falling edge, clear of the edge that launches the pulse
  always @(negedge clk_sys)
  begin
    if (rst_n === 1'b1 && dma_o.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        chk(11'h000, 11'h7FF);
      end
      else
      begin
        ent = exp_q.pop_front();
        chk({ent[DW+1] ? dma_o.field : ent[DW], dma_o.data}, ent[DW:0]);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial
  begin
    seed = 6;
    miscompares = 0;
    checks = 0;
    rst_n = 1'b0;
    mode_sel = VCF_ENT;
    port_enable = 1'b1;
    width_10b = 1'b0;
    transfer_line_count = LINES_RST;
    st = 0;
    lc = 0;
    seen_trs = 1'b0;
    pf = 1'b0;
    pv = 1'b0;
    fld = 1'b0;
    run(VCF_ENT, 1'b0, 16'h0003, 1'b1);
    run(VCF_VBL, 1'b1, 16'h0003, 1'b1);
    run(VCF_ACT, 1'b0, 16'h0003, 1'b1);
    run(VCF_ACT, 1'b1, 16'h0009, 1'b1);
    run(VCF_ACT, 1'b0, 16'h0000, 1'b1);
    run(VCF_ENT, 1'b1, 16'h0003, 1'b1);
    run(2'h3, 1'b0, 16'h0003, 1'b1);
    run(VCF_ENT, 1'b0, 16'h0003, 1'b0);
    results();
  end

  // A hang counts as a mismatch and ends the run
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    $display("Error at %0t: run did not finish", $time);
    results();
  end

endmodule  // vcf_top_tb_top
